// File: src/nvws_host.sv
`timescale 1ns/1ns
`default_nettype none
// Host controller: status polling, reset sequences and page writes of 1 to PAGE_BYTES bytes.
module nvws_host #(
	parameter int unsigned PAGE_BYTES = nvws_pkg::PAGE_BYTES,
	parameter int unsigned POLL_MAX   = 2000000
) (
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	input  wire logic               req_i,
	input  wire nvws_pkg::nvws_cmd_t cmd_i,
	input  wire logic [15:0]        addr_i,
	input  wire logic [63:0]        data_i,
	input  wire logic [3:0]         nbytes_i,
	input  wire logic               prot_en_i,
	input  wire logic               dat_i,
	output logic                    sel_n_o,
	output logic                    gate_n_o,
	output logic                    strobe_n_o,
	output logic                    dat_o,
	output logic                    dat_oe_o,
	output logic                    prot_n_o,
	output logic                    ack_o,
	output nvws_pkg::nvws_resp_t    resp_o
);
	typedef enum logic [2:0] {
		NVWS_IDLE, NVWS_PROT, NVWS_RST, NVWS_ADDR, NVWS_DATA, NVWS_START,
		NVWS_POLL
	} nvws_st_t;

	logic rs1_q, rs2_q;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rs2_q <= rs1_q;
		end
	end

	nvws_st_t st_q, st_d;
	logic [1:0] step_q, step_d;
	logic [6:0] bit_q, bit_d;
	logic [6:0] nbits_q, nbits_d;
	logic [15:0] addr_q, addr_d;
	logic [63:0] data_q, data_d;
	logic [31:0] wait_q, wait_d;
	logic write_q, write_d;
	logic ack_d, prot_n_d;
	nvws_pkg::nvws_resp_t resp_d;
	logic go, cyc_done, rdat;
	nvws_pkg::nvws_cyc_t kind;
	logic c_sel, c_gate, c_strobe, c_dat, c_oe;

	nvws_cycle u_cycle (
		.clk_i     (clk_i),
		.rst_n_i   (rs2_q),
		.go_i      (go),
		.kind_i    (kind),
		.dat_i     (dat_i),
		.sel_n_o   (c_sel),
		.gate_n_o  (c_gate),
		.strobe_n_o(c_strobe),
		.dat_o     (c_dat),
		.dat_oe_o  (c_oe),
		.done_o    (cyc_done),
		.rdat_o    (rdat)
	);

	always_comb begin
		st_d = st_q;
		step_d = step_q;
		bit_d = bit_q;
		nbits_d = nbits_q;
		addr_d = addr_q;
		data_d = data_q;
		wait_d = wait_q;
		write_d = write_q;
		ack_d = 1'b0;
		resp_d = resp_o;
		resp_d.done = 1'b0;
		resp_d.refused = 1'b0;
		// Protect is released while enabled, but only between sequences, so a
		// running programming cycle is never affected. See [R16] and [R10].
		prot_n_d = prot_n_o;
		go = 1'b0;
		kind = nvws_pkg::NVWS_CYC_READ;
		unique case (st_q)
			NVWS_IDLE: begin
				prot_n_d = prot_en_i;
				if (req_i) begin
					ack_d = 1'b1;
					step_d = '0;
					addr_d = addr_i;
					data_d = data_i;
					nbits_d = 7'(nvws_pkg::BYTE_BITS) * 7'(nbytes_i);
					resp_d.busy = 1'b1;
					unique case (cmd_i)
						nvws_pkg::NVWS_CMD_STATUS: st_d = NVWS_POLL; // see [R1]
						nvws_pkg::NVWS_CMD_RESET: begin
							write_d = 1'b0;
							st_d = NVWS_RST;
						end
						nvws_pkg::NVWS_CMD_WRITE: begin
							// Zero or oversized pages, or protect held, are refused:
							// an incomplete sequence would program nothing anyway.
							if (!prot_en_i || nbytes_i == '0
								|| 32'(nbytes_i) > PAGE_BYTES) begin
								resp_d.refused = 1'b1;
								resp_d.busy = 1'b0;
								resp_d.done = 1'b1;
								st_d = NVWS_IDLE;
							end else begin
								write_d = 1'b1;
								wait_d = 32'(nvws_pkg::CYC_PROT);
								st_d = NVWS_PROT;
							end
						end
						default: st_d = NVWS_IDLE;
					endcase
				end
			end
			NVWS_PROT: begin
				prot_n_d = 1'b1;
				wait_d = wait_q - 1'b1;
				if (wait_q == '0) st_d = NVWS_RST;
			end
			NVWS_RST: begin
				// Read, write zero, read. See [R11] and [R7].
				go = (step_q != 2'd3);
				kind = (step_q == 2'd1) ? nvws_pkg::NVWS_CYC_WR0
					: nvws_pkg::NVWS_CYC_READ;
				if (cyc_done) begin
					step_d = step_q + 1'b1;
					if (step_q == 2'd2) begin
						step_d = '0;
						bit_d = '0;
						st_d = write_q ? NVWS_ADDR : NVWS_POLL;
					end
				end
				if (step_q == 2'd3) go = 1'b0;
			end
			NVWS_ADDR: begin
				go = 1'b1;
				kind = addr_q[15] ? nvws_pkg::NVWS_CYC_WR1 : nvws_pkg::NVWS_CYC_WR0;
				if (cyc_done) begin
					addr_d = {addr_q[14:0], 1'b0}; // see [R14]
					bit_d = bit_q + 1'b1;
					if (bit_q == 7'(nvws_pkg::ADDR_BITS - 1)) begin
						bit_d = '0;
						st_d = NVWS_DATA;
					end
				end
			end
			NVWS_DATA: begin
				go = 1'b1;
				kind = data_q[63] ? nvws_pkg::NVWS_CYC_WR1 : nvws_pkg::NVWS_CYC_WR0;
				if (cyc_done) begin
					data_d = {data_q[62:0], 1'b0};
					bit_d = bit_q + 1'b1;
					if (bit_q == nbits_q - 1'b1) begin
						st_d = NVWS_START;
					end
				end
			end
			NVWS_START: begin
				// Read ends the page load, write one, read launches it. See [R12], [R8].
				go = 1'b1;
				kind = (step_q == 2'd1) ? nvws_pkg::NVWS_CYC_WR1
					: nvws_pkg::NVWS_CYC_READ;
				if (cyc_done) begin
					step_d = step_q + 1'b1;
					if (step_q == 2'd2) begin
						step_d = '0;
						wait_d = POLL_MAX;
						st_d = NVWS_POLL;
					end
				end
			end
			NVWS_POLL: begin
				// Status read: low means programming, high means done. See [R3],
				// [R4], [R5]; a write polls until high or for POLL_MAX+1 reads, other commands read once. See [R15].
				go = 1'b1;
				if (cyc_done) begin
					resp_d.status = rdat;
					wait_d = wait_q - 1'b1;
					if (rdat || !write_q || wait_q == '0) begin
						resp_d.busy = 1'b0;
						resp_d.done = 1'b1;
						resp_d.refused = !rdat;
						write_d = 1'b0;
						st_d = NVWS_IDLE;
					end
				end
			end
			default: st_d = NVWS_IDLE;
		endcase
		if (cyc_done) go = 1'b0;
	end

	always_ff @(posedge clk_i or negedge rs2_q) begin
		if (!rs2_q) begin
			st_q <= NVWS_IDLE;
			step_q <= '0;
			bit_q <= '0;
			nbits_q <= '0;
			addr_q <= '0;
			data_q <= '0;
			wait_q <= '0;
			write_q <= 1'b0;
			ack_o <= 1'b0;
			resp_o <= '0;
			prot_n_o <= 1'b0;
			sel_n_o <= 1'b1;
			gate_n_o <= 1'b1;
			strobe_n_o <= 1'b1;
			dat_o <= 1'b0;
			dat_oe_o <= 1'b0;
		end else begin
			st_q <= st_d;
			step_q <= step_d;
			bit_q <= bit_d;
			nbits_q <= nbits_d;
			addr_q <= addr_d;
			data_q <= data_d;
			wait_q <= wait_d;
			write_q <= write_d;
			ack_o <= ack_d;
			resp_o <= resp_d;
			prot_n_o <= prot_n_d;
			sel_n_o <= c_sel;
			gate_n_o <= c_gate;
			strobe_n_o <= c_strobe;
			dat_o <= c_dat;
			dat_oe_o <= c_oe;
		end
	end
endmodule
`default_nettype wire

// File: src/nvws_pkg.sv
// How it works
// [R1] Status readable anytime by one read cycle.
// [R2] Status read: select low, gate low, strobe high.
// [R3] Data pin low while write busy.
// [R4] Data pin high once write done.
// [R5] Reset during write leaves write undisturbed.
// [R6] Power-up clears the write-enable latch.
// [R7] Reset sequence precedes every write sequence.
// [R8] Only start-write command launches programming.
// [R9] Finished write clears the write-enable latch.
// [R10] Protect low blocks latch and writes.
// [R11] Reset is read, write zero, read.
// [R12] Start-write is read, write one, read.
// [R13] Bit captured on first strobe/select rise.
// [R14] Reset, 16 address bits, bytes, start-write.
// [R15] Poll until high before next sequence; the host stops after POLL_MAX+1 reads.
// [R16] Protect drop lets running write finish.
package nvws_pkg;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned T_CYCLE_NS    = 300;
	localparam int unsigned T_LOW_NS      = 70;
	localparam int unsigned T_PROT_NS     = 500;
	localparam int unsigned CYC_LOW  = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_REST = (T_CYCLE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS - CYC_LOW;
	localparam int unsigned CYC_PROT = (T_PROT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ADDR_BITS = 16;
	localparam int unsigned PAGE_BYTES = 8;
	localparam int unsigned BYTE_BITS = 8;
	localparam int unsigned CNT_W = 8;

	typedef enum logic [1:0] {
		NVWS_CMD_STATUS,
		NVWS_CMD_WRITE,
		NVWS_CMD_RESET
	} nvws_cmd_t;

	// One bus cycle towards the device.
	typedef enum logic [1:0] {
		NVWS_CYC_READ,
		NVWS_CYC_WR0,
		NVWS_CYC_WR1
	} nvws_cyc_t;

	typedef struct packed {
		logic sel_n;
		logic gate_n;
		logic strobe_n;
		logic dat;
		logic dat_oe;
		logic prot_n;
	} nvws_pins_t;

	typedef struct packed {
		logic        busy;
		logic        done;
		logic        status;
		logic        refused;
	} nvws_resp_t;
endpackage

// File: src/nvws_cycle.sv
`timescale 1ns/1ns
`default_nettype none
// Runs one bus cycle; low phase then recovery, sampling the data pin on reads.
module nvws_cycle (
	input  wire logic               clk_i,
	input  wire logic               rst_n_i,
	input  wire logic               go_i,
	input  wire nvws_pkg::nvws_cyc_t kind_i,
	input  wire logic               dat_i,
	output logic                    sel_n_o,
	output logic                    gate_n_o,
	output logic                    strobe_n_o,
	output logic                    dat_o,
	output logic                    dat_oe_o,
	output logic                    done_o,
	output logic                    rdat_o
);
	typedef enum logic [1:0] {NVWS_C_IDLE, NVWS_C_LOW, NVWS_C_REST} nvws_cst_t;
	nvws_cst_t st_q, st_d;
	logic [nvws_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic sel_n_d, gate_n_d, strobe_n_d, dat_d, oe_d, done_d, rdat_d;
	nvws_pkg::nvws_cyc_t kind_q, kind_d;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		kind_d = kind_q;
		sel_n_d = 1'b1;
		gate_n_d = 1'b1;
		strobe_n_d = 1'b1;
		dat_d = dat_o;
		oe_d = dat_oe_o;
		done_d = 1'b0;
		rdat_d = rdat_o;
		unique case (st_q)
			NVWS_C_IDLE: begin
				oe_d = 1'b0;
				if (go_i) begin
					st_d = NVWS_C_LOW;
					kind_d = kind_i;
					cnt_d = nvws_pkg::CNT_W'(nvws_pkg::CYC_LOW);
				end
			end
			NVWS_C_LOW: begin
				sel_n_d = 1'b0;
				// Strobe and gate are never low together while selected.
				if (kind_q == nvws_pkg::NVWS_CYC_READ) begin
					gate_n_d = 1'b0; // see [R2]
					oe_d = 1'b0;
				end else begin
					strobe_n_d = 1'b0;
					oe_d = 1'b1;
					dat_d = (kind_q == nvws_pkg::NVWS_CYC_WR1);
				end
				cnt_d = cnt_q - 1'b1;
				if (cnt_q == '0) begin
					// Select and strobe rise together; the device latches the bit
					// on that first rise while data is still held. See [R13].
					sel_n_d = 1'b1;
					gate_n_d = 1'b1;
					strobe_n_d = 1'b1;
					if (kind_q == nvws_pkg::NVWS_CYC_READ) begin
						rdat_d = dat_i;
					end
					st_d = NVWS_C_REST;
					cnt_d = nvws_pkg::CNT_W'(nvws_pkg::CYC_REST);
				end
			end
			NVWS_C_REST: begin
				oe_d = 1'b0;
				cnt_d = cnt_q - 1'b1;
				if (cnt_q == '0) begin
					st_d = NVWS_C_IDLE;
					done_d = 1'b1;
				end
			end
			default: st_d = NVWS_C_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= NVWS_C_IDLE;
			cnt_q <= '0;
			kind_q <= nvws_pkg::NVWS_CYC_READ;
			sel_n_o <= 1'b1;
			gate_n_o <= 1'b1;
			strobe_n_o <= 1'b1;
			dat_o <= 1'b0;
			dat_oe_o <= 1'b0;
			done_o <= 1'b0;
			rdat_o <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			kind_q <= kind_d;
			sel_n_o <= sel_n_d;
			gate_n_o <= gate_n_d;
			strobe_n_o <= strobe_n_d;
			dat_o <= dat_d;
			dat_oe_o <= oe_d;
			done_o <= done_d;
			rdat_o <= rdat_d;
		end
	end
endmodule
`default_nettype wire

// File: sim/nvws_dev.sv
`timescale 1ns/1ns
`default_nettype none
// Behavioural device; busy time is shortened to keep runs short.
module nvws_dev #(
	parameter int BUSY_NS = 40000
) (
	input  wire logic sel_n_i,
	input  wire logic gate_n_i,
	input  wire logic strobe_n_i,
	input  wire logic prot_n_i,
	input  wire logic hd_i,
	input  wire logic hoe_i,
	output wire logic pin_o
);
	logic        busy = 1'b0;
	logic        wel = 1'b0;
	logic        wc = 1'b0;
	logic        rc = 1'b0;
	logic        pr = 1'b0;
	logic        pw = 1'b0;
	logic        pb = 1'b0;
	logic        lv = 1'b0;
	logic [95:0] sh = '0;
	int          nb = 0;
	int          nstart = 0;

	// Released pin toggles every cycle so a stale level never looks valid.
	always @(negedge sel_n_i) lv = ~lv;
	assign pin_o = hoe_i ? hd_i
		: ((!sel_n_i && !gate_n_i && strobe_n_i) ? !busy : lv);
	always @(negedge strobe_n_i) wc = 1'b1;
	always @(negedge gate_n_i) rc = 1'b1;
	always @(posedge sel_n_i or posedge strobe_n_i) begin
		if (wc) begin
			wc = 1'b0;
			pb = hd_i;
			pw = pr;
			pr = 1'b0;
			sh = {sh[94:0], hd_i};
			nb++;
		end else if (rc && sel_n_i) begin
			rc = 1'b0;
			if (pw && !pb && !busy) begin
				wel = prot_n_i;
				nb = 0;
			end else if (pw && pb) begin
				if (wel && prot_n_i && !busy && nb > 24 && (nb - 1) % 8 == 0) begin
					busy = 1'b1;
					nstart++;
				end
				nb = 0;
			end
			pw = 1'b0;
			pr = 1'b1;
		end
	end
	always @(negedge prot_n_i) wel = 1'b0;
	always @(posedge busy) begin
		#(BUSY_NS);
		busy = 1'b0;
		wel = 1'b0;
	end
endmodule
`default_nettype wire

// File: sim/nvws_host_chk.sv
`timescale 1ns/1ns
`default_nettype none
module nvws_host_chk (
	input  wire logic                 clk_i,
	input  wire logic                 reset_n_i,
	input  wire logic                 req_i,
	input  wire logic                 prot_en_i,
	input  wire logic                 sel_n_o,
	input  wire logic                 gate_n_o,
	input  wire logic                 strobe_n_o,
	input  wire logic                 dat_oe_o,
	input  wire logic                 prot_n_o,
	input  wire logic                 ack_o,
	input  wire nvws_pkg::nvws_resp_t resp_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	AST_READ_FORM: assert property (!gate_n_o |-> !sel_n_o && strobe_n_o && !dat_oe_o)
		else $error("read cycle malformed");
	AST_WRITE_FORM: assert property (!strobe_n_o |-> !sel_n_o && gate_n_o && dat_oe_o)
		else $error("write cycle malformed");
	// The low phase is nine clocks, the shortest whole count above the minimum.
	AST_LOW_LEN: assert property ($fell(sel_n_o) |-> (!sel_n_o)[*8] ##1 !sel_n_o ##1 sel_n_o)
		else $error("select low phase length wrong");
	AST_RECOVER: assert property ($rose(sel_n_o) |-> sel_n_o[*8])
		else $error("select recovery too short");
	AST_RISE_TOGETHER: assert property ($rose(strobe_n_o) |-> $rose(sel_n_o))
		else $error("strobe and select rise apart");
	AST_PROT_SETUP: assert property ($rose(prot_n_o) |-> $past(prot_en_i) ##0 sel_n_o[*8])
		else $error("protect release without enable or setup");
	// A refused write is answered at once with done instead of busy.
	AST_ACK_CAUSE: assert property (ack_o |-> $past(req_i) && (resp_o.busy || resp_o.done) ##1 !ack_o)
		else $error("acknowledge without request");
	AST_DONE_PULSE: assert property (resp_o.done |=> !resp_o.done && !resp_o.busy)
		else $error("done not a single pulse");
endmodule
bind nvws_host nvws_host_chk u_chk (
	.clk_i(clk_i),
	.reset_n_i(reset_n_i),
	.req_i(req_i),
	.prot_en_i(prot_en_i),
	.sel_n_o(sel_n_o),
	.gate_n_o(gate_n_o),
	.strobe_n_o(strobe_n_o),
	.dat_oe_o(dat_oe_o),
	.prot_n_o(prot_n_o),
	.ack_o(ack_o),
	.resp_o(resp_o)
);
`default_nettype wire

// File: sim/tb_nv_write_status_and_protect.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
	$display("ERROR %0t mismatch %h %h", $time, a, b); end end
module tb_nv_write_status_and_protect;
	logic                 clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic                 req = 1'b0;
	nvws_pkg::nvws_cmd_t  cmd = nvws_pkg::NVWS_CMD_STATUS;
	logic [15:0]          addr = '0;
	logic [63:0]          data = '0;
	logic [3:0]           nb = 4'h1;
	logic                 prot_en = 1'b0;
	wire logic            pin;
	logic                 sel_n, gate_n, strobe_n, hd, hoe, prot_n, ack;
	nvws_pkg::nvws_resp_t resp;
	int                   error_cnt = 0;
	int                   n_tests = 0;
	int                   cyc = 0;

	always #4 clk = ~clk;
	nvws_host #(.POLL_MAX(4)) DUT (.clk_i(clk), .reset_n_i(rst_n), .req_i(req),
		.cmd_i(cmd), .addr_i(addr), .data_i(data), .nbytes_i(nb),
		.prot_en_i(prot_en), .dat_i(pin), .sel_n_o(sel_n), .gate_n_o(gate_n),
		.strobe_n_o(strobe_n), .dat_o(hd), .dat_oe_o(hoe), .prot_n_o(prot_n),
		.ack_o(ack), .resp_o(resp));
	nvws_dev dev (.sel_n_i(sel_n), .gate_n_i(gate_n), .strobe_n_i(strobe_n),
		.prot_n_i(prot_n), .hd_i(hd), .hoe_i(hoe), .pin_o(pin));

	task automatic close_out;
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			close_out;
		end
	end
	task automatic run(input nvws_pkg::nvws_cmd_t c, input logic [15:0] a,
		input logic [63:0] d, input logic [3:0] n);
		@(posedge clk);
		req <= 1'b1;
		cmd <= c;
		addr <= a;
		data <= d;
		nb <= n;
		@(posedge clk);
		req <= 1'b0;
		// The response is taken at the edge that still shows done high.
		do @(posedge clk); while (resp.done !== 1'b1);
	endtask
	task automatic wait_dev;
		while (dev.busy) @(posedge clk);
	endtask
	task automatic t_idle;
		`CHK(dev.wel, 1'b0)
		run(nvws_pkg::NVWS_CMD_STATUS, '0, '0, 4'h1);
		`CHK(resp.status, 1'b1)
		`CHK(resp.busy, 1'b0)
	endtask
	task automatic t_page;
		prot_en <= 1'b1;
		run(nvws_pkg::NVWS_CMD_WRITE, 16'h01F8, 64'h0123_4567_89AB_CDEF, 4'h8);
		`CHK(dev.nstart, 1)
		`CHK(dev.sh[80:1], {16'h01F8, 64'h0123_4567_89AB_CDEF})
		`CHK(resp.status, 1'b0)
		prot_en <= 1'b0;
		run(nvws_pkg::NVWS_CMD_RESET, '0, '0, 4'h1);
		`CHK(resp.status, 1'b0)
		`CHK(dev.busy, 1'b1)
		wait_dev;
		`CHK(dev.wel, 1'b0)
		run(nvws_pkg::NVWS_CMD_STATUS, '0, '0, 4'h1);
		`CHK(resp.status, 1'b1)
	endtask
	task automatic t_refuse;
		run(nvws_pkg::NVWS_CMD_WRITE, 16'h0010, '1, 4'h1);
		`CHK(resp.refused, 1'b1)
		prot_en <= 1'b1;
		run(nvws_pkg::NVWS_CMD_WRITE, 16'h0010, '1, 4'h0);
		`CHK(resp.refused, 1'b1)
		run(nvws_pkg::NVWS_CMD_WRITE, 16'h0010, '1, 4'h9);
		`CHK(resp.refused, 1'b1)
		`CHK(dev.nstart, 1)
	endtask
	task automatic t_byte;
		run(nvws_pkg::NVWS_CMD_WRITE, 16'h0000, 64'hA5FF_FFFF_FFFF_FFFF, 4'h1);
		`CHK(dev.nstart, 2)
		`CHK(dev.sh[24:1], {16'h0000, 8'hA5})
		wait_dev;
		run(nvws_pkg::NVWS_CMD_STATUS, '0, '0, 4'h1);
		`CHK(resp.status, 1'b1)
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_idle;
		t_page;
		t_refuse;
		t_byte;
		close_out;
	end
endmodule
`default_nettype wire
